// >>> hw/dcf_fifo.sv
`timescale 1ns/10ps
// Functional notes
// RQ1 - Mode pin high at reset selects fall-through with valid and space indicators.
// RQ2 - Mode pin low at reset selects standard mode with empty and full flags.
// RQ3 - Fall-through: first word reaches output after three read edges unrequested.
// RQ4 - Standard: reader requests every word with read enable low.
// RQ5 - Writer holds write enable low; data taken on write clock edges.
// RQ6 - Fall-through: valid indicator goes low three read edges after first write.
// RQ7 - Fall-through: almost-empty goes high at n + 2 stored words.
// RQ8 - Fall-through: half-full goes low at (D-1)/2+2 words.
// RQ9 - Fall-through capacity is memory depth plus the output register word.
// RQ10 - Almost-full goes low at D-m words in the active mode.
// RQ11 - Fall-through: space indicator goes high at D words; writes then blocked.
// RQ12 - Fall-through: read from full clears space indicator after two write edges.
// RQ13 - Fall-through: almost-empty goes low when n + 1 words remain.
// RQ14 - Fall-through: valid indicator high after last word read; reads blocked.
// RQ15 - Valid indicator three stages deep; others two stages deep.
// RQ16 - Standard: empty flag goes high two read edges after first write.
// RQ17 - Standard: almost-empty goes high at n + 1 stored words.
// RQ18 - Standard: half-full goes low at D/2 + 1 words.
// RQ19 - Standard: full flag low at D words; writes then blocked.
// RQ20 - Standard: read from full raises full flag after two write edges.
// RQ21 - Standard: almost-empty goes low when n words remain.
// RQ22 - Standard: empty flag low after last read; empty ignores read enable.
// RQ23 - Reset clears pointers and puts every flag in its empty state.
module dcf_fifo
    import dcf_pkg::*;
(
    input  wire logic      clock,
    input  wire logic      read_clock,
    input  wire logic      arst_n,
    input  wire logic      timing_mode_serial_in,
    input  wire logic      offset_load_n,
    input  wire logic      offset_default_sel0,
    input  wire logic      offset_default_sel1,
    input  wire logic      write_en_n,
    input  wire dcf_data_t write_data,
    input  wire logic      read_en_n,
    output dcf_data_t      output_data_bus,
    output logic           fall_through_mode,
    output logic           empty_flag_n,
    output logic           full_flag_n,
    output logic           output_valid_n,
    output logic           input_space_n,
    output logic           almost_empty_flag_n,
    output logic           almost_full_flag_n,
    output logic           half_full_flag_n
);

    ////////////////////////////////////////////////////////////////////////
    // Storage: written only on the write clock, read only on the read clock
    dcf_data_t mem [DEPTH];

    // Read-side state that the write side synchronises
    dcf_ptr_t  r_gray_r;
    logic      r_valid_r;

    ////////////////////////////////////////////////////////////////////////
    // Write domain: reset release and configuration capture
    logic [SYNC_N-1:0] w_rst_r;
    logic              w_rst_n;
    logic [2:0]        w_pin_s1_r;
    logic [2:0]        w_pin_s2_r;
    logic              w_mode_s1_r;
    logic              w_mode_s2_r;
    logic              w_done_r;
    dcf_cfg_s          w_cfg_r;
    dcf_cfg_s          w_cfg_nxt;

    assign w_rst_n = w_rst_r[SYNC_N-1];

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            w_rst_r <= '0;
        end else begin
            w_rst_r <= {w_rst_r[SYNC_N-2:0], 1'b1};
        end
    end

    // Straps pass two flops, then are frozen on the third edge after release
    always_ff @(posedge clock or negedge w_rst_n) begin
        if (!w_rst_n) begin
            w_pin_s1_r  <= '0;
            w_pin_s2_r  <= '0;
            w_mode_s1_r <= 1'b0;
            w_mode_s2_r <= 1'b0;
        end else begin
            w_pin_s1_r  <= {offset_load_n, offset_default_sel0, offset_default_sel1};
            w_pin_s2_r  <= w_pin_s1_r;
            w_mode_s1_r <= timing_mode_serial_in;
            w_mode_s2_r <= w_mode_s1_r;
        end
    end

    logic [1:0] w_cap_cnt_r;
    wire        w_cap_now = (w_cap_cnt_r == 2'h2) && !w_done_r;

    assign w_cfg_nxt.mode   = w_mode_s2_r ? MODE_FT : MODE_STD;  // [RQ1] [RQ2]
    assign w_cfg_nxt.offset = default_offset(w_pin_s2_r);

    always_ff @(posedge clock or negedge w_rst_n) begin
        if (!w_rst_n) begin
            w_cap_cnt_r <= '0;
            w_done_r    <= 1'b0;
            w_cfg_r     <= CFG_RST;
        end else begin
            if (w_cap_cnt_r != 2'h2) begin
                w_cap_cnt_r <= w_cap_cnt_r + 2'h1;
            end
            if (w_cap_now) begin
                w_done_r <= 1'b1;
                w_cfg_r  <= w_cfg_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write domain: pointer, fill level and flags
    dcf_ptr_t w_ptr_r;
    dcf_ptr_t w_gray_r;
    dcf_ptr_t w_rg_s1_r;
    dcf_ptr_t w_rg_s2_r;
    logic     w_ov_s1_r;
    logic     w_ov_s2_r;

    wire       w_ft      = (w_cfg_r.mode == MODE_FT);
    wire       w_ov      = w_ft & w_ov_s2_r;
    dcf_ptr_t  w_mem_cnt;
    dcf_cnt_t  w_total;
    dcf_cnt_t  w_af_thr;
    dcf_cnt_t  w_half_thr;
    wire       w_mem_full;
    wire       w_take;

    assign w_mem_cnt  = w_ptr_r - gray2bin(w_rg_s2_r);
    assign w_mem_full = (w_mem_cnt == MEM_FULL);
    // Output register word counts toward the fall-through capacity
    assign w_total    = {1'b0, w_mem_cnt} + {{(CNT_W-1){1'b0}}, w_ov};  // [RQ9]
    assign w_af_thr   = (w_ft ? CAP_FT : CAP_STD) - w_cfg_r.offset;    // [RQ10]
    assign w_half_thr = w_ft ? HALF_FT : HALF_STD;                     // [RQ8] [RQ18]
    // Writes before the straps are frozen would be counted in the wrong mode
    assign w_take     = !write_en_n && !w_mem_full && w_done_r;        // [RQ5] [RQ11] [RQ19]

    always_ff @(posedge clock) begin
        if (w_take) begin
            mem[w_ptr_r[ADDR_W-1:0]] <= write_data;
        end
    end

    always_ff @(posedge clock or negedge w_rst_n) begin
        if (!w_rst_n) begin
            w_ptr_r  <= '0;   // [RQ23]
            w_gray_r <= '0;
        end else if (w_take) begin
            w_ptr_r  <= w_ptr_r + 14'h0001;
            w_gray_r <= bin2gray(w_ptr_r + 14'h0001);
        end
    end

    // Read pointer and valid level cross in two stages
    always_ff @(posedge clock or negedge w_rst_n) begin
        if (!w_rst_n) begin
            w_rg_s1_r <= '0;
            w_rg_s2_r <= '0;
            w_ov_s1_r <= 1'b0;
            w_ov_s2_r <= 1'b0;
        end else begin
            w_rg_s1_r <= r_gray_r;   // [RQ15]
            w_rg_s2_r <= w_rg_s1_r;
            w_ov_s1_r <= r_valid_r;
            w_ov_s2_r <= w_ov_s1_r;
        end
    end

    assign fall_through_mode  = w_ft;
    assign full_flag_n        = !(!w_ft && w_mem_full);        // [RQ19] [RQ20]
    assign input_space_n      = w_ft && w_mem_full;            // [RQ11] [RQ12]
    assign almost_full_flag_n = !(w_total >= w_af_thr);        // [RQ10]
    assign half_full_flag_n   = !(w_total >= w_half_thr);      // [RQ8] [RQ18]

    ////////////////////////////////////////////////////////////////////////
    // Read domain: reset release and its own copy of the straps
    logic [SYNC_N-1:0] r_rst_r;
    logic              r_rst_n;
    logic [2:0]        r_pin_s1_r;
    logic [2:0]        r_pin_s2_r;
    logic              r_mode_s1_r;
    logic              r_mode_s2_r;
    logic [1:0]        r_cap_cnt_r;
    logic              r_done_r;
    dcf_cfg_s          r_cfg_r;
    dcf_cfg_s          r_cfg_nxt;

    assign r_rst_n = r_rst_r[SYNC_N-1];

    always_ff @(posedge read_clock or negedge arst_n) begin
        if (!arst_n) begin
            r_rst_r <= '0;
        end else begin
            r_rst_r <= {r_rst_r[SYNC_N-2:0], 1'b1};
        end
    end

    always_ff @(posedge read_clock or negedge r_rst_n) begin
        if (!r_rst_n) begin
            r_pin_s1_r  <= '0;
            r_pin_s2_r  <= '0;
            r_mode_s1_r <= 1'b0;
            r_mode_s2_r <= 1'b0;
        end else begin
            r_pin_s1_r  <= {offset_load_n, offset_default_sel0, offset_default_sel1};
            r_pin_s2_r  <= r_pin_s1_r;
            r_mode_s1_r <= timing_mode_serial_in;
            r_mode_s2_r <= r_mode_s1_r;
        end
    end

    assign r_cfg_nxt.mode   = r_mode_s2_r ? MODE_FT : MODE_STD;  // [RQ1] [RQ2]
    assign r_cfg_nxt.offset = default_offset(r_pin_s2_r);

    always_ff @(posedge read_clock or negedge r_rst_n) begin
        if (!r_rst_n) begin
            r_cap_cnt_r <= '0;
            r_done_r    <= 1'b0;
            r_cfg_r     <= CFG_RST;
        end else begin
            if (r_cap_cnt_r != 2'h2) begin
                r_cap_cnt_r <= r_cap_cnt_r + 2'h1;
            end
            if ((r_cap_cnt_r == 2'h2) && !r_done_r) begin
                r_done_r <= 1'b1;
                r_cfg_r  <= r_cfg_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read domain: pointer, output register and flags
    dcf_ptr_t  r_ptr_r;
    dcf_ptr_t  r_wg_s1_r;
    dcf_ptr_t  r_wg_s2_r;
    dcf_data_t r_data_r;

    wire       r_ft = (r_cfg_r.mode == MODE_FT);
    dcf_ptr_t  r_mem_cnt;
    dcf_cnt_t  r_words;
    dcf_cnt_t  r_ae_thr;
    wire       r_nonempty;
    wire       r_std_pop;
    wire       r_ft_load;
    wire       r_load;

    assign r_mem_cnt  = gray2bin(r_wg_s2_r) - r_ptr_r;
    assign r_nonempty = (r_mem_cnt != '0);
    // Empty memory masks read enable in both modes
    assign r_std_pop  = !r_ft && !read_en_n && r_nonempty;              // [RQ4] [RQ22]
    // Unrequested load of the output register is what makes first-word fall through
    assign r_ft_load  = r_ft && r_nonempty && (!r_valid_r || !read_en_n); // [RQ3]
    assign r_load     = r_std_pop || r_ft_load;
    assign r_words    = {1'b0, r_mem_cnt} + {{(CNT_W-1){1'b0}}, r_ft & r_valid_r};
    assign r_ae_thr   = r_cfg_r.offset + (r_ft ? AE_ADD_F : AE_ADD_S);   // [RQ7] [RQ17]

    always_ff @(posedge read_clock or negedge r_rst_n) begin
        if (!r_rst_n) begin
            r_wg_s1_r <= '0;
            r_wg_s2_r <= '0;
        end else begin
            r_wg_s1_r <= w_gray_r;   // [RQ15]
            r_wg_s2_r <= r_wg_s1_r;
        end
    end

    always_ff @(posedge read_clock or negedge r_rst_n) begin
        if (!r_rst_n) begin
            r_ptr_r  <= '0;   // [RQ23]
            r_gray_r <= '0;
        end else if (r_load) begin
            r_ptr_r  <= r_ptr_r + 14'h0001;
            r_gray_r <= bin2gray(r_ptr_r + 14'h0001);
        end
    end

    always_ff @(posedge read_clock) begin
        if (r_load) begin
            r_data_r <= mem[r_ptr_r[ADDR_W-1:0]];
        end
    end

    // Third stage of the valid indicator
    always_ff @(posedge read_clock or negedge r_rst_n) begin
        if (!r_rst_n) begin
            r_valid_r <= 1'b0;
        end else if (r_ft_load) begin
            r_valid_r <= 1'b1;                   // [RQ6] [RQ15]
        end else if (!read_en_n) begin
            r_valid_r <= 1'b0;                   // [RQ14]
        end
    end

    assign output_data_bus     = r_data_r;
    assign empty_flag_n        = !r_ft && r_nonempty;            // [RQ16] [RQ22]
    assign output_valid_n      = !(r_ft && r_valid_r);           // [RQ6] [RQ14]
    assign almost_empty_flag_n = (r_words >= r_ae_thr);          // [RQ13] [RQ21]

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_ft_idle_with_data;
        r_ft && !r_valid_r && r_nonempty;
    endsequence

    sequence s_ft_hold;
        r_ft && r_valid_r && read_en_n;
    endsequence

    property p_first_word_loads;
        @(posedge read_clock) disable iff (!r_rst_n)
        s_ft_idle_with_data |=> !output_valid_n && (r_ptr_r == $past(r_ptr_r) + 14'h0001);
    endproperty

    chk_ft_first_word: assert property (p_first_word_loads) // [RQ3]
        else $error("first word did not fall through");

    chk_ft_word_hold: assert property ( // [RQ3]
        @(posedge read_clock) disable iff (!r_rst_n)
        s_ft_hold ##1 1'b1 |-> $stable(output_data_bus) && !output_valid_n)
        else $error("output word changed without read enable");

    chk_std_read_step: assert property ( // [RQ4]
        @(posedge read_clock) disable iff (!r_rst_n)
        !r_ft && !read_en_n && empty_flag_n |=> r_ptr_r == $past(r_ptr_r) + 14'h0001)
        else $error("standard read did not advance");

    chk_empty_read_ignored: assert property ( // [RQ22]
        @(posedge read_clock) disable iff (!r_rst_n)
        !r_nonempty && !(r_ft && r_valid_r) |=> $stable(r_ptr_r) && output_valid_n)
        else $error("read taken from empty memory");

    chk_ft_last_read: assert property ( // [RQ14]
        @(posedge read_clock) disable iff (!r_rst_n)
        r_ft && r_valid_r && !r_nonempty && !read_en_n |=> output_valid_n)
        else $error("valid indicator stayed low after last read");

    chk_full_write_block: assert property ( // [RQ19]
        @(posedge clock) disable iff (!w_rst_n)
        w_mem_full && !write_en_n |=> $stable(w_ptr_r))
        else $error("write accepted while full");

    chk_ft_space_flag: assert property ( // [RQ11]
        @(posedge clock) disable iff (!w_rst_n)
        w_ft && (w_mem_cnt == MEM_FULL - 14'h0001) && w_take && (w_rg_s1_r == w_rg_s2_r)
        |=> input_space_n && full_flag_n)
        else $error("space indicator not raised at capacity");

    chk_full_release: assert property ( // [RQ20]
        @(posedge clock) disable iff (!w_rst_n)
        !w_ft && !full_flag_n && (w_rg_s1_r != w_rg_s2_r) |=> full_flag_n)
        else $error("full flag not released two edges after read");

    chk_mode_frozen: assert property ( // [RQ1]
        @(posedge clock) disable iff (!w_rst_n)
        w_done_r ##1 w_done_r |-> $stable(w_cfg_r))
        else $error("mode changed after reset");

    chk_reset_state: assert property ( // [RQ23]
        @(posedge read_clock) disable iff (!arst_n)
        $rose(r_rst_n) |-> !empty_flag_n && !almost_empty_flag_n && (r_ptr_r == '0))
        else $error("read side not empty after reset");

    chk_ae_std_level: assert property ( // [RQ21]
        @(posedge read_clock) disable iff (!r_rst_n)
        !r_ft && r_done_r && (r_mem_cnt == r_cfg_r.offset[PTR_W-1:0]) |-> !almost_empty_flag_n)
        else $error("almost-empty high at n words");

endmodule

// >>> hw/dcf_pkg.sv
package dcf_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Geometry
    localparam int unsigned DATA_W  = 18;
    localparam int unsigned ADDR_W  = 13;
    localparam int unsigned PTR_W   = 14;
    localparam int unsigned CNT_W   = 15;
    localparam int unsigned DEPTH   = 8192;
    localparam int unsigned SYNC_N  = 2;

    typedef logic [DATA_W-1:0] dcf_data_t;
    typedef logic [PTR_W-1:0]  dcf_ptr_t;
    typedef logic [CNT_W-1:0]  dcf_cnt_t;

    ////////////////////////////////////////////////////////////////////////
    // Capacities and flag thresholds
    localparam dcf_ptr_t MEM_FULL  = 14'h2000;
    localparam dcf_cnt_t CAP_STD   = 15'h2000;
    localparam dcf_cnt_t CAP_FT    = 15'h2001;
    localparam dcf_cnt_t HALF_STD  = 15'h1001;
    localparam dcf_cnt_t HALF_FT   = 15'h1002;
    localparam dcf_cnt_t AE_ADD_S  = 15'h0001;
    localparam dcf_cnt_t AE_ADD_F  = 15'h0002;

    ////////////////////////////////////////////////////////////////////////
    // Default offsets, indexed by {load_n, sel0, sel1}
    localparam dcf_cnt_t OFS_LLL = 15'h007F;
    localparam dcf_cnt_t OFS_LLH = 15'h01FF;
    localparam dcf_cnt_t OFS_LHL = 15'h00FF;
    localparam dcf_cnt_t OFS_LHH = 15'h003F;
    localparam dcf_cnt_t OFS_HLL = 15'h03FF;
    localparam dcf_cnt_t OFS_HLH = 15'h001F;
    localparam dcf_cnt_t OFS_HHL = 15'h000F;
    localparam dcf_cnt_t OFS_HHH = 15'h0007;

    typedef enum logic [1:0] {
        MODE_STD = 2'b01,
        MODE_FT  = 2'b10
    } dcf_mode_e;

    typedef struct packed {
        dcf_mode_e mode;
        dcf_cnt_t  offset;
    } dcf_cfg_s;

    localparam dcf_cfg_s CFG_RST = '{mode: MODE_STD, offset: OFS_LLL};

    function automatic dcf_cnt_t default_offset(input logic [2:0] sel);
        case (sel)
            3'b000:  default_offset = OFS_LLL;
            3'b001:  default_offset = OFS_LLH;
            3'b010:  default_offset = OFS_LHL;
            3'b011:  default_offset = OFS_LHH;
            3'b100:  default_offset = OFS_HLL;
            3'b101:  default_offset = OFS_HLH;
            3'b110:  default_offset = OFS_HHL;
            default: default_offset = OFS_HHH;
        endcase
    endfunction

    function automatic dcf_ptr_t bin2gray(input dcf_ptr_t b);
        bin2gray = b ^ (b >> 1);
    endfunction

    function automatic dcf_ptr_t gray2bin(input dcf_ptr_t g);
        dcf_ptr_t b;
        b[PTR_W-1] = g[PTR_W-1];
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        gray2bin = b;
    endfunction

endpackage

// >>> bench/dcf_far_side.sv
`timescale 1ns/10ps
module dcf_far_side
    import dcf_pkg::*;
(
    input  wire logic clock,
    input  wire logic read_clock,
    output logic      write_en_n,
    output dcf_data_t write_data,
    output logic      read_en_n
);

    initial begin
        write_en_n = 1'b1;
        write_data = '0;
        read_en_n  = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Writer: back-to-back burst, idle bus inverted so stale data never matches
    task automatic push(input int first, input int count);
        for (int i = 0; i < count; i++) begin
            @(negedge clock);
            write_en_n = 1'b0;
            write_data = dcf_data_t'(first + i);
        end
        @(negedge clock);
        write_en_n = 1'b1;
        write_data = ~write_data;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reader: called at a falling edge, one request, then a stall cycle
    task automatic pull();
        read_en_n = 1'b0;
        @(negedge read_clock);
        read_en_n = 1'b1;
        @(negedge read_clock);
    endtask

endmodule

// >>> bench/test_dual_clock_fifo_flag_timing.sv
`timescale 1ns/10ps
module test_dual_clock_fifo_flag_timing;
    import dcf_pkg::*;

    logic      clock;
    logic      read_clock;
    logic      arst_n;
    logic      mode_pin;
    logic      load_n;
    logic      sel0;
    logic      sel1;
    logic      ft;
    logic      write_en_n;
    logic      read_en_n;
    dcf_data_t write_data;
    dcf_data_t output_data_bus;
    logic      ft_mode;
    logic      empty_n;
    logic      full_n;
    logic      valid_n;
    logic      space_n;
    logic      aempty_n;
    logic      afull_n;
    logic      half_n;
    int        fail_count;
    int        check_count;
    int        wr_n;
    int        rd_n;
    int        cnt;
    wire logic full_ind  = ft ? space_n : ~full_n;
    wire logic empty_ind = ft ? valid_n : ~empty_n;

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Offset start keeps the two clocks out of phase
    initial begin
        read_clock = 1'b0;
        #13;
        forever #40 read_clock = ~read_clock;
    end

    dcf_fifo DUT (
        .clock                 (clock),
        .read_clock            (read_clock),
        .arst_n                (arst_n),
        .timing_mode_serial_in (mode_pin),
        .offset_load_n         (load_n),
        .offset_default_sel0   (sel0),
        .offset_default_sel1   (sel1),
        .write_en_n            (write_en_n),
        .write_data            (write_data),
        .read_en_n             (read_en_n),
        .output_data_bus       (output_data_bus),
        .fall_through_mode     (ft_mode),
        .empty_flag_n          (empty_n),
        .full_flag_n           (full_n),
        .output_valid_n        (valid_n),
        .input_space_n         (space_n),
        .almost_empty_flag_n   (aempty_n),
        .almost_full_flag_n    (afull_n),
        .half_full_flag_n      (half_n)
    );

    dcf_far_side far (
        .clock      (clock),
        .read_clock (read_clock),
        .write_en_n (write_en_n),
        .write_data (write_data),
        .read_en_n  (read_en_n)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Long enough for both synchronised sides to catch up
    task automatic settle();
        repeat (8) @(negedge read_clock);
    endtask

    task automatic wait_ready();
        int i;
        i = 0;
        @(negedge read_clock);
        while (empty_ind !== 1'b0 && i < 20) begin
            @(negedge read_clock);
            i++;
        end
        if (empty_ind !== 1'b0) begin
            check("ready", 0, empty_ind);
            print_verdict();
        end
    endtask

    task automatic fill_to(input int k);
        if (k > wr_n) begin
            far.push(wr_n, k - wr_n);
        end
        wr_n = k;
        settle();
    endtask

    task automatic read_one(input bit measure);
        wait_ready();
        if (ft) check("data", rd_n, output_data_bus);
        fork
            far.pull();
            if (measure) begin
                @(posedge read_clock);
                cnt = 0;
                while (full_ind !== 1'b0 && cnt < 10) begin
                    @(posedge clock);
                    #1;
                    cnt++;
                end
            end
        join
        if (measure) check("full release", 1, cnt >= 2 && cnt <= 3);
        if (measure && full_ind !== 1'b0) print_verdict();
        if (!ft) check("data", rd_n, output_data_bus);
        rd_n++;
    endtask

    task automatic drain_to(input int k);
        while (wr_n - rd_n > k) begin
            read_one(1'b0);
        end
        settle();
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic run(input logic mode, input logic [2:0] straps, input dcf_cnt_t n);
        int cap;
        int half;
        int thr;
        int nn;
        int lat;
        nn   = int'(n);
        cap  = mode ? 8193 : 8192;
        half = mode ? (cap - 1) / 2 + 2 : cap / 2 + 1;
        thr  = nn + (mode ? 2 : 1);
        lat  = mode ? 3 : 2;
        wr_n = 0;
        rd_n = 0;
        @(negedge clock);
        arst_n = 1'b0;
        ft = mode;
        mode_pin = mode;
        {load_n, sel0, sel1} = straps;
        repeat (4) @(negedge clock);
        check("reset flags", 7'b0110011, {empty_n, full_n, valid_n, space_n, aempty_n, afull_n, half_n});
        arst_n = 1'b1;
        repeat (10) @(negedge clock);
        check("idle flags", {mode, 7'b0110011}, {ft_mode, empty_n, full_n, valid_n, space_n, aempty_n, afull_n, half_n});
        fork
            far.push(0, 1);
            begin
                @(negedge clock);
                @(posedge clock);
                cnt = 0;
                while (empty_ind !== 1'b0 && cnt < 10) begin
                    @(posedge read_clock);
                    #1;
                    cnt++;
                end
            end
        join
        check("first word latency", 1, cnt >= lat && cnt <= lat + 1);
        if (empty_ind !== 1'b0) print_verdict();
        wr_n = 1;
        fill_to(thr - 1);
        check("almost empty", 0, aempty_n);
        fill_to(thr);
        check("almost empty", 1, aempty_n);
        fill_to(half - 1);
        check("half full", 1, half_n);
        fill_to(half);
        check("half full", 0, half_n);
        fill_to(cap - nn - 1);
        check("almost full", 1, afull_n);
        fill_to(cap - nn);
        check("almost full", 0, afull_n);
        fill_to(cap - 1);
        check("full", 0, full_ind);
        fill_to(cap);
        check("full", 1, full_ind);
        // Dropped word; its value never appears in the drained sequence
        far.push(32'h0003_FFFF, 1);
        settle();
        check("full", 1, full_ind);
        read_one(1'b1);
        drain_to(thr);
        check("almost empty", 1, aempty_n);
        drain_to(thr - 1);
        check("almost empty", 0, aempty_n);
        drain_to(0);
        check("empty", 1, empty_ind);
        repeat (3) far.pull();
        check("empty", 1, empty_ind);
        if (!mode) check("held data", cap - 1, output_data_bus);
    endtask

    initial begin
        fail_count = 0;
        check_count = 0;
        arst_n = 1'b0;
        mode_pin = 1'b0;
        ft = 1'b0;
        {load_n, sel0, sel1} = 3'b000;
        wr_n = 0;
        rd_n = 0;
        cnt = 0;
        repeat (4) @(negedge clock);
        run(1'b0, 3'b111, OFS_HHH);
        run(1'b1, 3'b100, OFS_HLL);
        print_verdict();
    end

endmodule
